/* src/as3_uart.sv */
// full-duplex asynchronous serial port with double-buffered paths
`timescale 1ns/1ns
module as3_uart import as3_pkg::*; #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// register port
	input wire as3_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// serial line and baud sources, all asynchronous
	input wire logic i_rxd,
	input wire logic i_external_baud_pin,
	input wire logic i_low_speed_oscillator,
	input wire logic i_high_speed_oscillator,
	output logic o_txd,
	// interrupt vector request and deep standby wake
	output logic o_irq_req,
	output logic o_wake_req
);

	// ************************
	// checks and helpers
	// ************************
	if (ADDR_W != 16) begin : g_bad_addr
		$error("as3_uart: register offsets need a 16-bit address");
	end

	// bit period limit, in pacing units
	function automatic logic [16:0] as3_limit(input logic mode1, input logic presc, input logic [7:0] div);
		logic [16:0] base;
		base = 17'(div) + AS3_STEP_ONE;
		if (mode1) begin
			return AS3_LSO_HZ;
		end
		return presc ? (base << AS3_SHIFT_X16) : (base << AS3_SHIFT_X4);
	endfunction

	// fractional pacer: returns {tick, new accumulator}
	function automatic logic [17:0] as3_pace(input logic [16:0] acc, input logic [16:0] step,
		input logic [16:0] limit);
		logic [16:0] sum;
		sum = acc + step;
		if (sum >= limit) begin
			return {1'b1, 17'(sum - limit)};
		end
		return {1'b0, sum};
	endfunction

	// ************************
	// state
	// ************************
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [7:0] ctl;
		logic [7:0] fmt;
		logic [7:0] thold;
		logic [7:0] rhold;
		logic [7:0] div;
		as3_tx_st_t tx_st;
		logic [8:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [16:0] tx_acc;
		logic txd;
		as3_rx_st_t rx_st;
		logic [7:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [16:0] rx_acc;
		logic rx_perr;
		logic [7:0] rdata;
	} as3_state_t;

	as3_state_t st_ff;
	as3_state_t nxt_st;
	logic mode1;
	logic par_on;
	logic src_tick;
	logic [16:0] step;
	logic [16:0] limit;
	logic [17:0] tx_p;
	logic [17:0] rx_p;
	logic wr_thold;
	logic rd_rhold;
	logic tx_load;
	logic rx_done;
	logic rx_bit;

	always_comb begin
		nxt_st = st_ff;
		// the first stage feeds only the second; logic reads stage two and three
		nxt_st.s1 = {i_high_speed_oscillator, i_low_speed_oscillator, i_external_baud_pin, i_rxd};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		rx_bit = st_ff.s2[AS3_S_RXD];

		mode1 = (st_ff.div == AS3_RST_BYTE);
		par_on = !mode1 && st_ff.fmt[AS3_B_PEN];
		// mode 1 always paces from the crystal whatever the source field says
		unique case (mode1 ? AS3_SRC_LSO : st_ff.fmt[AS3_B_SRC_HI:AS3_B_SRC_LO])
			AS3_SRC_SYS: src_tick = 1'b1;
			AS3_SRC_EXT: src_tick = st_ff.s2[AS3_S_EXT] && !st_ff.s3[AS3_S_EXT];
			AS3_SRC_LSO: src_tick = st_ff.s2[AS3_S_LSO] && !st_ff.s3[AS3_S_LSO];
			AS3_SRC_HSO: src_tick = st_ff.s2[AS3_S_HSO] && !st_ff.s3[AS3_S_HSO];
		endcase
		step = mode1 ? AS3_M1_BPS : AS3_STEP_ONE;
		limit = as3_limit(mode1, st_ff.fmt[AS3_B_PRESC], st_ff.div);
		tx_p = src_tick ? as3_pace(st_ff.tx_acc, step, limit) : {1'b0, st_ff.tx_acc};
		rx_p = src_tick ? as3_pace(st_ff.rx_acc, step, limit) : {1'b0, st_ff.rx_acc};

		wr_thold = i_bus.wr && (i_bus.addr == AS3_OFS_THOLD);
		rd_rhold = i_bus.rd && (i_bus.addr == AS3_OFS_RHOLD);
		tx_load = 1'b0;
		rx_done = 1'b0;

		// ************************
		// register writes
		// ************************
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				AS3_OFS_CTRL: begin
					nxt_st.ctl[AS3_B_FIN_IE] = i_bus.wdata[AS3_B_FIN_IE];
					nxt_st.ctl[AS3_B_VAC_IE] = i_bus.wdata[AS3_B_VAC_IE];
					nxt_st.ctl[AS3_B_RUN] = i_bus.wdata[AS3_B_RUN];
					nxt_st.ctl[AS3_B_RDY_IE] = i_bus.wdata[AS3_B_RDY_IE];
					// sticky flags: writing zero clears, writing one is ignored
					nxt_st.ctl[AS3_B_FIN] = st_ff.ctl[AS3_B_FIN] && i_bus.wdata[AS3_B_FIN];
					nxt_st.ctl[AS3_B_ERR] = st_ff.ctl[AS3_B_ERR] && i_bus.wdata[AS3_B_ERR];
				end
				AS3_OFS_FMT: begin
					nxt_st.fmt = i_bus.wdata;
					nxt_st.fmt[AS3_B_WFLG] = st_ff.fmt[AS3_B_WFLG] && i_bus.wdata[AS3_B_WFLG];
				end
				AS3_OFS_THOLD: begin
					nxt_st.thold = i_bus.wdata;
					nxt_st.ctl[AS3_B_VAC] = 1'b0;
				end
				AS3_OFS_DIV: nxt_st.div = i_bus.wdata;
				default: ;
			endcase
		end
		if (rd_rhold) begin
			nxt_st.ctl[AS3_B_RDY] = 1'b0;
		end

		// ************************
		// register reads
		// ************************
		nxt_st.rdata = AS3_RST_BYTE;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				AS3_OFS_CTRL: nxt_st.rdata = st_ff.ctl;
				AS3_OFS_FMT: nxt_st.rdata = st_ff.fmt;
				AS3_OFS_THOLD: nxt_st.rdata = st_ff.thold;
				AS3_OFS_RHOLD: nxt_st.rdata = st_ff.rhold;
				AS3_OFS_DIV: nxt_st.rdata = st_ff.div;
				default: nxt_st.rdata = AS3_RST_BYTE;
			endcase
		end

		// ************************
		// wake detect
		// ************************
		if (st_ff.fmt[AS3_B_WIE] && !rx_bit) begin
			nxt_st.fmt[AS3_B_WFLG] = 1'b1;
		end

		// ************************
		// transmitter
		// ************************
		nxt_st.tx_acc = tx_p[16:0];
		unique case (st_ff.tx_st)
			AS3_TX_IDLE: begin
				nxt_st.txd = 1'b1;
				nxt_st.tx_acc = '0;
				tx_load = !st_ff.ctl[AS3_B_VAC];
			end
			AS3_TX_START: begin
				if (tx_p[17]) begin
					nxt_st.txd = st_ff.tx_sh[0];
					nxt_st.tx_st = AS3_TX_DATA;
					nxt_st.tx_cnt = '0;
				end
			end
			AS3_TX_DATA: begin
				if (tx_p[17]) begin
					nxt_st.tx_sh = {1'b1, st_ff.tx_sh[8:1]};
					nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
					if (st_ff.tx_cnt == AS3_LAST_DATA) begin
						nxt_st.tx_cnt = '0;
						// the ninth shifter bit is the precomputed parity bit
						nxt_st.txd = par_on ? st_ff.tx_sh[1] : 1'b1;
						nxt_st.tx_st = par_on ? AS3_TX_PAR : AS3_TX_STOP;
					end else begin
						nxt_st.txd = st_ff.tx_sh[1];
					end
				end
			end
			AS3_TX_PAR: begin
				if (tx_p[17]) begin
					nxt_st.txd = 1'b1;
					nxt_st.tx_st = AS3_TX_STOP;
				end
			end
			AS3_TX_STOP: begin
				if (tx_p[17]) begin
					nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
					if (st_ff.tx_cnt != '0 || !st_ff.fmt[AS3_B_STOP2]) begin
						nxt_st.tx_st = AS3_TX_IDLE;
						// back-to-back: a waiting byte starts with no idle bit
						tx_load = !st_ff.ctl[AS3_B_VAC];
						if (st_ff.ctl[AS3_B_VAC]) begin
							nxt_st.ctl[AS3_B_FIN] = 1'b1;
						end
					end
				end
			end
			default: nxt_st.tx_st = AS3_TX_IDLE;
		endcase
		if (tx_load && st_ff.ctl[AS3_B_RUN]) begin
			// parity: even makes the ones count even, odd makes it odd
			nxt_st.tx_sh = {(^st_ff.thold) ^ st_ff.fmt[AS3_B_ODD], st_ff.thold};
			nxt_st.tx_st = AS3_TX_START;
			nxt_st.tx_acc = '0;
			nxt_st.txd = 1'b0;
			nxt_st.ctl[AS3_B_FIN] = 1'b0;
			// a write in the same cycle queues a fresh byte, so it keeps vacant low
			nxt_st.ctl[AS3_B_VAC] = !wr_thold;
		end else begin
			tx_load = 1'b0;
		end

		// ************************
		// receiver
		// ************************
		nxt_st.rx_acc = rx_p[16:0];
		unique case (st_ff.rx_st)
			AS3_RX_IDLE: begin
				if (!rx_bit) begin
					// start the pacer half a period in so samples land mid-bit
					nxt_st.rx_acc = limit >> 1;
					nxt_st.rx_st = AS3_RX_START;
					nxt_st.rx_perr = 1'b0;
				end
			end
			AS3_RX_START: begin
				if (rx_p[17]) begin
					// a high level at mid-start is a glitch, not a frame
					nxt_st.rx_st = rx_bit ? AS3_RX_IDLE : AS3_RX_DATA;
					nxt_st.rx_cnt = '0;
				end
			end
			AS3_RX_DATA: begin
				if (rx_p[17]) begin
					nxt_st.rx_sh = {rx_bit, st_ff.rx_sh[7:1]};
					nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
					if (st_ff.rx_cnt == AS3_LAST_DATA) begin
						nxt_st.rx_st = par_on ? AS3_RX_PAR : AS3_RX_STOP;
					end
				end
			end
			AS3_RX_PAR: begin
				if (rx_p[17]) begin
					nxt_st.rx_perr = (^st_ff.rx_sh) ^ st_ff.fmt[AS3_B_ODD] ^ rx_bit;
					nxt_st.rx_st = AS3_RX_STOP;
				end
			end
			AS3_RX_STOP: begin
				if (rx_p[17]) begin
					// only the first stop is checked; a low next bit is a new start
					nxt_st.rx_st = AS3_RX_IDLE;
					rx_done = 1'b1;
					nxt_st.rhold = st_ff.rx_sh;
					nxt_st.ctl[AS3_B_RDY] = 1'b1;
					if (st_ff.rx_perr || !rx_bit || (st_ff.ctl[AS3_B_RDY] && !rd_rhold)) begin
						nxt_st.ctl[AS3_B_ERR] = 1'b1;
					end
				end
			end
			default: nxt_st.rx_st = AS3_RX_IDLE;
		endcase

		// halting parks both paths; flags and buffers are kept
		if (!st_ff.ctl[AS3_B_RUN]) begin
			nxt_st.tx_st = AS3_TX_IDLE;
			nxt_st.rx_st = AS3_RX_IDLE;
			nxt_st.txd = 1'b1;
			nxt_st.tx_acc = '0;
			nxt_st.rx_acc = '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_ff <= '0;
			st_ff.s1 <= AS3_SYNC_IDLE;
			st_ff.s2 <= AS3_SYNC_IDLE;
			st_ff.s3 <= AS3_SYNC_IDLE;
			st_ff.ctl <= AS3_RST_CTRL;
			st_ff.fmt <= AS3_RST_FMT;
			st_ff.tx_st <= AS3_TX_IDLE;
			st_ff.rx_st <= AS3_RX_IDLE;
			st_ff.txd <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************
	// outputs
	// ************************
	assign o_rdata = st_ff.rdata;
	assign o_txd = st_ff.txd;
	// one level for every source; it also serves to release light standby
	assign o_irq_req = (st_ff.ctl[AS3_B_FIN] && st_ff.ctl[AS3_B_FIN_IE])
		|| (st_ff.ctl[AS3_B_VAC] && st_ff.ctl[AS3_B_VAC_IE])
		|| (st_ff.ctl[AS3_B_RDY] && st_ff.ctl[AS3_B_RDY_IE])
		|| (st_ff.fmt[AS3_B_WFLG] && st_ff.fmt[AS3_B_WIE]);
	assign o_wake_req = st_ff.fmt[AS3_B_WFLG];

	// ************************
	// assertions
	// ************************
	a_irq_on_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(st_ff.ctl[AS3_B_RDY] && st_ff.ctl[AS3_B_RDY_IE]) |-> o_irq_req)
		else $error("ready with enable did not raise interrupt");
	a_wake_sets: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(st_ff.fmt[AS3_B_WIE] && !st_ff.s2[AS3_S_RXD]) |=> (st_ff.fmt[AS3_B_WFLG] && o_wake_req))
		else $error("low receive line with wake enable missed the flag");
	a_load_clears_fin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		tx_load |=> (!st_ff.ctl[AS3_B_FIN] && st_ff.tx_st == AS3_TX_START && !o_txd))
		else $error("transfer to shifter did not clear finished or start frame");
	a_write_clears_vac: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		wr_thold |=> !st_ff.ctl[AS3_B_VAC])
		else $error("holding write left vacant set");
	a_load_sets_vac: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(tx_load && !wr_thold) |=> (st_ff.ctl[AS3_B_VAC] && st_ff.tx_sh[7:0] == $past(st_ff.thold)))
		else $error("transfer did not set vacant or load shifter");
	a_halt_idles: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!st_ff.ctl[AS3_B_RUN] |=> (st_ff.tx_st == AS3_TX_IDLE && st_ff.rx_st == AS3_RX_IDLE && o_txd))
		else $error("halted port kept running");
	a_read_clears_rdy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(rd_rhold && !rx_done) |=> !st_ff.ctl[AS3_B_RDY])
		else $error("holding read did not clear ready");
	a_rx_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		rx_done |=> (st_ff.ctl[AS3_B_RDY] && st_ff.rhold == $past(st_ff.rx_sh)))
		else $error("end of reception did not copy shifter");
	a_stop_error: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(rx_done && !st_ff.s2[AS3_S_RXD]) |=> st_ff.ctl[AS3_B_ERR])
		else $error("low stop bit did not set error");
	a_finish_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(st_ff.ctl[AS3_B_FIN]) |-> (st_ff.tx_st == AS3_TX_IDLE && $past(st_ff.tx_st) == AS3_TX_STOP))
		else $error("finished flag rose outside end of stop");

endmodule

/* src/as3_pkg.sv */
// constants and types shared by the serial port three design
package as3_pkg;
	// ************************
	// register map
	// ************************
	localparam logic [15:0] AS3_OFS_CTRL = 16'h7F70;
	localparam logic [15:0] AS3_OFS_FMT = 16'h7F71;
	localparam logic [15:0] AS3_OFS_THOLD = 16'h7F72;
	localparam logic [15:0] AS3_OFS_RHOLD = 16'h7F73;
	localparam logic [15:0] AS3_OFS_DIV = 16'h7F75;
	localparam logic [7:0] AS3_RST_CTRL = 8'h20;
	localparam logic [7:0] AS3_RST_FMT = 8'h00;
	localparam logic [7:0] AS3_RST_BYTE = 8'h00;

	// port_control_status bits
	localparam int AS3_B_FIN = 7;
	localparam int AS3_B_FIN_IE = 6;
	localparam int AS3_B_VAC = 5;
	localparam int AS3_B_VAC_IE = 4;
	localparam int AS3_B_RUN = 3;
	localparam int AS3_B_ERR = 2;
	localparam int AS3_B_RDY = 1;
	localparam int AS3_B_RDY_IE = 0;
	// frame_format_control bits
	localparam int AS3_B_STOP2 = 7;
	localparam int AS3_B_PRESC = 6;
	localparam int AS3_B_SRC_HI = 5;
	localparam int AS3_B_SRC_LO = 4;
	localparam int AS3_B_ODD = 3;
	localparam int AS3_B_PEN = 2;
	localparam int AS3_B_WFLG = 1;
	localparam int AS3_B_WIE = 0;

	// ************************
	// baud clock
	// ************************
	localparam logic [1:0] AS3_SRC_SYS = 2'h0;
	localparam logic [1:0] AS3_SRC_EXT = 2'h1;
	localparam logic [1:0] AS3_SRC_LSO = 2'h2;
	localparam logic [1:0] AS3_SRC_HSO = 2'h3;
	// synchroniser lanes
	localparam int AS3_S_RXD = 0;
	localparam int AS3_S_EXT = 1;
	localparam int AS3_S_LSO = 2;
	localparam int AS3_S_HSO = 3;
	localparam logic [3:0] AS3_SYNC_IDLE = 4'hF;
	// mode 0 prescale shifts: x4 and x16
	localparam int AS3_SHIFT_X4 = 2;
	localparam int AS3_SHIFT_X16 = 4;
	// mode 1: fixed 9600 bit/s paced from the 32.768 kHz crystal
	localparam logic [16:0] AS3_LSO_HZ = 17'h08000;
	localparam logic [16:0] AS3_M1_BPS = 17'h02580;
	localparam logic [16:0] AS3_STEP_ONE = 17'h00001;
	localparam logic [3:0] AS3_LAST_DATA = 4'h7;

	typedef enum logic [2:0] {AS3_TX_IDLE, AS3_TX_START, AS3_TX_DATA, AS3_TX_PAR, AS3_TX_STOP} as3_tx_st_t;
	typedef enum logic [2:0] {AS3_RX_IDLE, AS3_RX_START, AS3_RX_DATA, AS3_RX_PAR, AS3_RX_STOP} as3_rx_st_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} as3_bus_req_t;
endpackage

/* verification/as3_remote_dev.sv */
// far-end serial device model for the serial port bench
`timescale 1ns/1ns
module as3_remote_dev (
	// clock and frame settings
	input wire logic i_ref_clk,
	input wire logic [15:0] i_period,
	input wire logic i_par_en,
	input wire logic i_odd,
	// serial lines
	input wire logic i_txd,
	output logic o_rxd
);
	// each entry: stop level, parity good, data byte
	logic [9:0] got_q[$];

	initial o_rxd = 1'b1;

	task automatic put_bit(input logic b);
		o_rxd <= b;
		repeat (i_period) @(posedge i_ref_clk);
	endtask

	task automatic send(input logic [7:0] d, input logic bad_par);
		put_bit(1'b0);
		for (int i = 0; i < 8; i++) put_bit(d[i]);
		if (i_par_en) put_bit((^d) ^ i_odd ^ bad_par);
		put_bit(1'b1);
	endtask

	// short low pulse, too short to pass for a start bit
	task automatic hold_low(input int n);
		o_rxd <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
		o_rxd <= 1'b1;
	endtask

	// samples mid-bit from the start edge, checks only the first stop
	always begin : rx_side
		logic [7:0] d;
		logic p_ok;
		@(negedge i_txd);
		repeat (i_period / 2) @(posedge i_ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (i_period) @(posedge i_ref_clk);
			d[i] = i_txd;
		end
		p_ok = 1'b1;
		if (i_par_en) begin
			repeat (i_period) @(posedge i_ref_clk);
			p_ok = (i_txd === ((^d) ^ i_odd));
		end
		repeat (i_period) @(posedge i_ref_clk);
		got_q.push_back({i_txd, p_ok, d});
	end
endmodule

/* verification/tb_as3_uart.sv */
// self-checking bench: register traffic and frames against the far-end model
`timescale 1ns/1ns
module tb_as3_uart import as3_pkg::*; ;
	logic clk, rst_n, txd, rxd, irq, wake, hso, ext, lso;
	as3_bus_req_t bus;
	logic [7:0] rdata;
	logic [15:0] period;
	logic par_en, odd;
	logic [31:0] seed = 32'hC5AA849C;
	int error_cnt = 0;
	int comparisons = 0;
	logic [15:0] offs[6] = '{AS3_OFS_CTRL, AS3_OFS_FMT, AS3_OFS_THOLD, AS3_OFS_RHOLD, AS3_OFS_DIV, 16'h7F74};
	logic [7:0] rstv[6] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	as3_uart DUT (
		.i_ref_clk(clk),
		.i_rst_n(rst_n),
		.i_bus(bus),
		.o_rdata(rdata),
		.i_rxd(rxd),
		.i_external_baud_pin(ext),
		.i_low_speed_oscillator(lso),
		.i_high_speed_oscillator(hso),
		.o_txd(txd),
		.o_irq_req(irq),
		.o_wake_req(wake)
	);
	as3_remote_dev rem (.i_ref_clk(clk), .i_period(period), .i_par_en(par_en), .i_odd(odd), .i_txd(txd), .o_rxd(rxd));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// fast source at a quarter of the clock, out of phase with it
	initial begin
		hso = 1'b0;
		forever #40 hso = ~hso;
	end
	// pin source at half the clock; crystal sped up so a mode 1 frame stays short
	initial begin
		ext = 1'b0;
		forever #20 ext = ~ext;
	end
	initial begin
		lso = 1'b0;
		forever #80 lso = ~lso;
	end

	// ************************
	// tasks
	// ************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic tally_and_finish();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	// source phase and synchronisers shift the frame by a few clocks
	task automatic chk_time(input string what, input int exp, input int got);
		comparisons++;
		if (got < exp - 7 || got > exp + 7) begin
			error_cnt++;
			$display("wrong value %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk(what, exp, rdata);
		@(posedge clk);
	endtask

	task automatic pop_chk(input logic [7:0] d);
		chk("far end byte", {22'h0, 2'b11, d}, (rem.got_q.size() > 0) ? rem.got_q.pop_front() : 32'hFFFFFFFF);
	endtask

	task automatic rx_chk(input logic [7:0] exp_ctrl, input logic [7:0] exp_byte);
		rd_chk("status after frame", AS3_OFS_CTRL, exp_ctrl);
		rd_chk("received byte", AS3_OFS_RHOLD, exp_byte);
		wr(AS3_OFS_CTRL, 8'h48);
		rd_chk("status after read", AS3_OFS_CTRL, 8'h68);
	endtask

	// ************************
	// sequence
	// ************************
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] d;
		logic quiet;
		time t0;
		int n;
		int nb;
		rst_n = 1'b0;
		bus = '0;
		period = 16'd8;
		par_en = 1'b0;
		odd = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("idle pins", 3'b100, {txd, irq, wake});
		@(posedge clk);
		foreach (offs[i]) rd_chk("reset value", offs[i], rstv[i]);
		wr(AS3_OFS_DIV, 8'h01);
		r = rnd();
		d = r[7:0];
		wr(AS3_OFS_THOLD, d);
		wr(AS3_OFS_RHOLD, ~d);
		wr(16'h7F74, 8'hFF);
		quiet = 1'b1;
		repeat (40) @(negedge clk) quiet &= txd;
		@(posedge clk);
		chk("line while halted", 1'b1, quiet);
		rd_chk("halted status", AS3_OFS_CTRL, 8'h00);
		rd_chk("holding readback", AS3_OFS_THOLD, d);
		rd_chk("receive holding", AS3_OFS_RHOLD, 8'h00);
		rd_chk("unmapped", 16'h7F74, 8'h00);
		wr(AS3_OFS_CTRL, 8'h08);
		repeat (100) @(posedge clk);
		pop_chk(d);
		rd_chk("status after frame", AS3_OFS_CTRL, 8'hA8);
		for (int c = 0; c < 4; c++) begin
			par_en = (c != 0);
			odd = c[1];
			period = (c == 0) ? 16'd8 : (c == 1) ? 16'd16 : 16'd32;
			nb = 10 + (c != 0) + c[0];
			wr(AS3_OFS_FMT, {c[0], c == 2, (c == 3) ? AS3_SRC_HSO : (c == 1) ? AS3_SRC_EXT : AS3_SRC_SYS, odd, par_en, 2'b00});
			wr(AS3_OFS_CTRL, 8'hC8);
			r = rnd();
			wr(AS3_OFS_THOLD, r[7:0]);
			t0 = $time;
			wr(AS3_OFS_THOLD, r[15:8]);
			n = 0;
			while (irq !== 1'b1 && n < 9000) begin
				@(negedge clk);
				n++;
			end
			chk_time("finish time", 2 * nb * period, int'(($time - t0) / 20));
			@(posedge clk);
			pop_chk(r[7:0]);
			pop_chk(r[15:8]);
			wr(AS3_OFS_CTRL, 8'h48);
			@(negedge clk);
			chk("irq after clear", 1'b0, irq);
			@(posedge clk);
			wr(AS3_OFS_CTRL, 8'h58);
			@(negedge clk);
			chk("irq on vacant", 1'b1, irq);
			@(posedge clk);
			wr(AS3_OFS_CTRL, 8'h48);
			r = rnd();
			rem.send(r[7:0], 1'b0);
			rx_chk(8'h6A, r[7:0]);
			r = rnd();
			if (c == 0) begin
				rem.send(r[15:8], 1'b0);
			end
			rem.send(r[7:0], c != 0);
			rx_chk(8'h6E, r[7:0]);
		end
		// mode 1: zero divider, crystal pacing; parity, prescale and source are ignored
		wr(AS3_OFS_DIV, 8'h00);
		wr(AS3_OFS_FMT, 8'h5C);
		par_en = 1'b0;
		odd = 1'b0;
		period = 16'd27;
		r = rnd();
		wr(AS3_OFS_THOLD, r[7:0]);
		repeat (340) @(posedge clk);
		pop_chk(r[7:0]);
		rd_chk("mode 1 status", AS3_OFS_CTRL, 8'hE8);
		wr(AS3_OFS_CTRL, 8'h48);
		rem.send(r[15:8], 1'b0);
		repeat (20) @(posedge clk);
		rx_chk(8'h6A, r[15:8]);
		wr(AS3_OFS_FMT, 8'h01);
		rem.hold_low(2);
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk("wake and irq", 2'b11, {wake, irq});
		@(posedge clk);
		rd_chk("wake flag", AS3_OFS_FMT, 8'h03);
		wr(AS3_OFS_FMT, 8'h00);
		@(negedge clk);
		chk("wake cleared", 1'b0, wake);
		tally_and_finish();
	end
endmodule
